// ===== dv/pin_function_strap_latch_bench.sv
// self-checking bench: straps, pin muxing and wake sources over ahb-lite
// assumes the board model resolves ports a, b, e, j and k from o/oe; port h comes straight from the board
`timescale 1ns/1ps
module pin_function_strap_latch_bench;
   logic        ref_clk, nrst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        modc, irq_n, nmi_n, net_tx, net_rx, scl_low, sda_low;
   logic        scl_in, sda_in, tag_lo, pull_en, osc, rom, mirq, nmirq;
   logic        kirq, wake, osc_float, x, e_rom, e_osc;
   logic [15:0] bus_rdata;
   int          err_total, n_checks;
   pin_strap_pkg::pins_in_t  pins_in, board;
   pin_strap_pkg::pins_out_t pins_out, gpio;
   pin_strap_pkg::ext_bus_t  bus;
   pin_strap_pkg::mode_t     op_mode;

   assign hready = hreadyout;

   pin_function_strap_latch DUT (.ref_clk(ref_clk), .nrst(nrst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pins_in(pins_in), .mode_strap_c_pin(modc),
      .maskable_irq_n_pin(irq_n), .nonmaskable_irq_n_pin(nmi_n),
      .pins_out(pins_out), .gpio(gpio), .bus(bus), .bus_rdata(bus_rdata),
      .net_tx(net_tx), .net_rx(net_rx), .i2c_scl_low(scl_low),
      .i2c_sda_low(sda_low), .i2c_scl_in(scl_in), .i2c_sda_in(sda_in),
      .tag_low_half(tag_lo), .strap_pullup_en(pull_en),
      .osc_select_strap(osc), .op_mode(op_mode), .rom_enable_bit(rom),
      .maskable_irq_in(mirq), .nonmaskable_irq_in(nmirq),
      .key_wakeup_irq(kirq), .wake_req(wake));

   strap_board board_model (.pins_out(pins_out), .board(board),
      .osc_float(osc_float), .strap_pullup_en(pull_en), .pins_in(pins_in));

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   // bounded: a slave that never answers ends the run
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      if (k >= 50) begin
         err_total++;
         complete_run();
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] ofs,
                      input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, ofs};
      hwrite <= wr;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic do_reset(input logic [2:0] m, input logic r, o, fl);
      @(posedge ref_clk);
      nrst <= 1'b0;
      modc <= m[2];
      board.e[7:5] <= {o, m[1:0]};
      board.k[7] <= r;
      osc_float <= fl;
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
   endtask

   // ****************************************************************
   // sequence
   // ****************************************************************
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      {nrst, hsel, hwrite, htrans, haddr, hwdata, modc} = '0;
      {net_tx, scl_low, sda_low, osc_float, err_total, n_checks} = '0;
      {irq_n, nmi_n} = 2'b11;
      hsize = 3'h2;
      board = '1;
      gpio = '0;
      bus = '0;
      for (int i = 0; i < 8; i++) begin
         do_reset(i[2:0], i[1], i[2], i == 3);
         settle(3);
         e_rom = (i == 5 || i == 7) ? i[1] : (i == 0 || i == 4 || i == 6);
         e_osc = (i == 3) ? 1'b1 : i[2];
         chk(op_mode, i[2:0]);
         chk(osc, e_osc);
         chk(rom, e_rom);
         chk({hresp, pull_en}, 2'b00);
         ahb(1'b0, pin_strap_pkg::OFS_STRAP, 32'h0);
         chk(rd, {e_rom, i[2:0], e_osc});
         board.e[7:5] <= ~board.e[7:5];
         board.k[7] <= ~board.k[7];
         modc <= ~modc;
         settle(4);
         chk({rom, op_mode, osc}, {e_rom, i[2:0], e_osc});
      end
      $display("test straps complete");
      do_reset(3'b111, 1'b1, 1'b1, 1'b0);
      settle(3);
      @(posedge ref_clk);
      bus <= '{20'h5a3c7, 16'hbeef, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'b00};
      settle(2);
      chk({pins_out.a_o, pins_out.b_o, pins_out.a_oe, pins_out.b_oe},
          32'ha3c7ffff);
      chk({pins_out.k_o[7], pins_out.k_o[5:0], pins_out.e_o[2]},
          {1'b0, 6'h16, 1'b1});
      @(posedge ref_clk);
      bus.addr_phase <= 1'b0;
      bus.write <= 1'b1;
      settle(2);
      chk({pins_out.a_o, pins_out.b_o, pins_out.e_o[2]}, 17'h17dde);
      ahb(1'b1, pin_strap_pkg::OFS_CTRL, 32'h5);
      bus.free_cycle <= 1'b1;
      bus.low_strobe_n <= 1'b0;
      settle(2);
      chk({pins_out.e_o[7], pins_out.e_oe[7], pins_out.e_o[3],
           pins_out.e_oe[3]}, 4'b1101);
      chk(bus_rdata, 16'hbeef);
      @(posedge ref_clk);
      bus.free_cycle <= 1'b0;
      settle(2);
      chk(pins_out.e_o[7], 1'b0);
      ahb(1'b1, pin_strap_pkg::OFS_CTRL, 32'h2);
      settle(2);
      x = pins_out.e_o[4];
      settle(1);
      chk({pins_out.e_oe[4], pins_out.e_o[4]}, {1'b1, ~x});
      ahb(1'b1, pin_strap_pkg::OFS_CTRL, 32'h8);
      bus.queue_track <= 2'b10;
      settle(2);
      chk(pins_out.e_o[6:5], 2'b10);
      ahb(1'b1, pin_strap_pkg::OFS_CTRL, 32'h10);
      scl_low <= 1'b1;
      settle(4);
      chk({pins_out.j_oe[7], pins_out.j_o[7]}, 2'b10);
      chk({scl_in, sda_in, net_rx}, 3'b011);
      ahb(1'b1, pin_strap_pkg::OFS_CTRL, 32'h0);
      scl_low <= 1'b0;
      net_tx <= 1'b1;
      board.j[6] <= 1'b0;
      settle(4);
      chk({pins_out.j_oe[7], pins_out.j_o[7]}, 2'b11);
      chk({scl_in, sda_in, net_rx}, 3'b110);
      ahb(1'b1, pin_strap_pkg::OFS_CTRL, 32'h24);
      board.e[3] <= 1'b0;
      settle(4);
      chk({tag_lo, pins_out.e_oe[3]}, 2'b10);
      $display("test pin functions complete");
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         irq_n <= k[0];
         nmi_n <= ~k[0];
         settle(4);
         chk({mirq, nmirq, wake}, k ? 3'b011 : 3'b101);
         @(posedge ref_clk);
         {irq_n, nmi_n} <= 2'b11;
         settle(4);
         ahb(1'b0, pin_strap_pkg::OFS_WAKE, 32'h0);
         chk(rd, 32'h1 << k);
         ahb(1'b1, pin_strap_pkg::OFS_WAKE, 32'h1 << k);
         ahb(1'b0, pin_strap_pkg::OFS_WAKE, 32'h0);
         chk(rd, 32'h0);
      end
      ahb(1'b1, pin_strap_pkg::OFS_KWU, 32'h1);
      board.h[1:0] <= 2'b00;
      settle(4);
      chk({kirq, wake}, 2'b11);
      ahb(1'b0, pin_strap_pkg::OFS_WAKE, 32'h0);
      chk(rd, 32'h4);
      ahb(1'b1, pin_strap_pkg::OFS_WAKE, 32'h4);
      ahb(1'b0, pin_strap_pkg::OFS_WAKE, 32'h0);
      chk({rd[30:0], kirq}, 32'h0);
      ahb(1'b1, 8'h10, 32'hffffffff);
      ahb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b1, pin_strap_pkg::OFS_STRAP, 32'h0);
      ahb(1'b0, pin_strap_pkg::OFS_STRAP, 32'h0);
      chk(rd, 32'h1f);
      $display("test wake and map complete");
      complete_run();
   end
endmodule

// ===== dv/strap_board.sv
// board model: strap wiring and other pin drivers
// assumes oe high means the block drives the pin, else the board does
`timescale 1ns/1ps
module strap_board (
   input  wire pin_strap_pkg::pins_out_t pins_out,
   input  wire pin_strap_pkg::pins_in_t  board,
   input  wire logic                     osc_float,
   input  wire logic                     strap_pullup_en,
   output pin_strap_pkg::pins_in_t       pins_in
);
   logic [7:0] e_ext;

   function automatic logic [7:0] res(input logic [7:0] o, oe, ext);
      return (o & oe) | (ext & ~oe);
   endfunction

   // floating strap: pull-up only in reset, drifts once released
   always_comb begin
      e_ext = board.e;
      if (osc_float)
         e_ext[7] = strap_pullup_en ? 1'b1 : ~board.e[7];
   end

   assign pins_in.a = res(pins_out.a_o, pins_out.a_oe, board.a);
   assign pins_in.b = res(pins_out.b_o, pins_out.b_oe, board.b);
   assign pins_in.e = res(pins_out.e_o, pins_out.e_oe, e_ext);
   assign pins_in.h = board.h;
   assign pins_in.j = res(pins_out.j_o, pins_out.j_oe, board.j);
   assign pins_in.k = res(pins_out.k_o, pins_out.k_oe, board.k);
endmodule

// ===== src/pin_function_strap_latch.sv
// pin function multiplexer with reset strap capture and wakeup sources
// assumes pins are resolved outside from o/oe; ahb-lite single slave
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
//
// Function
// - capture oscillator select strap once at reset release
// - strap 1 picks loop oscillator, 0 full swing or external clock
// - pull-up during reset makes a floating strap select loop oscillator
// - port e bit 6 level latched into mode strap b at release
// - port e bit 5 level latched into mode strap a at release
// - normal expanded modes take rom enable from port k bit 7 strap
// - other modes give rom enable fixed 1 or 0 per mode
// - expanded modes show free bus cycles on port e bit 7 when enabled
// - bus clock driven on port e bit 4 when enabled
// - expanded modes drive low byte strobe on port e bit 3 when enabled and tagging is off
// - expanded modes drive read/write on port e bit 2
// - maskable interrupt input accepted asynchronously, wakes from stop
// - non-maskable interrupt input accepted asynchronously, also wakes
// - enabled key wakeup pins of ports h and j raise wake interrupt
// - expanded modes put low address/data byte on port b
// - expanded modes put address bits 19 to 14 on port k 5:0
// - expanded modes use port k bit 7 as emulation chip select
// - port e bits 6 and 5 output queue tracking 1 and 0 when enabled
// - port j 7/6 select network tx/rx or i2c clock/data
// - expanded modes put high address/data byte on port a
module pin_function_strap_latch (
   input  wire logic                  ref_clk,
   input  wire logic                  nrst,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   input  wire pin_strap_pkg::pins_in_t  pins_in,
   input  wire logic                  mode_strap_c_pin,
   input  wire logic                  maskable_irq_n_pin,
   input  wire logic                  nonmaskable_irq_n_pin,
   output pin_strap_pkg::pins_out_t   pins_out,
   input  wire pin_strap_pkg::pins_out_t  gpio,
   input  wire pin_strap_pkg::ext_bus_t   bus,
   output logic [15:0]                bus_rdata,
   input  wire logic                  net_tx,
   output logic                       net_rx,
   input  wire logic                  i2c_scl_low,
   input  wire logic                  i2c_sda_low,
   output logic                       i2c_scl_in,
   output logic                       i2c_sda_in,
   output logic                       tag_low_half,
   output logic                       strap_pullup_en,
   output logic                       osc_select_strap,
   output pin_strap_pkg::mode_t       op_mode,
   output logic                       rom_enable_bit,
   output logic                       maskable_irq_in,
   output logic                       nonmaskable_irq_in,
   output logic                       key_wakeup_irq,
   output logic                       wake_req
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   localparam int SW = $bits(pin_strap_pkg::pins_in_t) + 3;

   logic [SW-1:0]           sync_q;
   pin_strap_pkg::pins_in_t pin_s;
   logic                    modc_s;
   logic                    irq_n_s;
   logic                    nmi_n_s;

   sync2 #(.W(SW)) u_sync (
      .ref_clk (ref_clk),
      .d       ({pins_in, mode_strap_c_pin, maskable_irq_n_pin,
                 nonmaskable_irq_n_pin}),
      .q       (sync_q)
   );

   assign pin_s    = sync_q[SW-1:3];
   assign modc_s   = sync_q[2];
   assign irq_n_s  = sync_q[1];
   assign nmi_n_s  = sync_q[0];

   // ****************************************************************
   // strap capture at reset release
   // ****************************************************************
   logic                 in_reset_reg;
   logic                 osc_reg;
   pin_strap_pkg::mode_t mode_reg;
   logic                 rom_reg;
   logic                 capture;
   logic                 expanded;

   assign capture  = nrst && in_reset_reg;
   assign expanded = pin_strap_pkg::is_expanded(mode_reg) && !in_reset_reg;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         in_reset_reg <= 1'b1;
      end else begin
         in_reset_reg <= 1'b0;
      end
   end

   // pins float to the pull-up while nothing drives them in reset
   assign strap_pullup_en = in_reset_reg;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         osc_reg <= pin_strap_pkg::OSC_LOOP;
      end else if (capture) begin
         osc_reg <= pin_s.e[7];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         mode_reg <= pin_strap_pkg::MODE_SPECIAL_SINGLE;
      end else if (capture) begin
         mode_reg <= pin_strap_pkg::mode_t'({modc_s, pin_s.e[6],
                                             pin_s.e[5]});
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rom_reg <= 1'b0;
      end else if (capture) begin
         rom_reg <= pin_strap_pkg::rom_reset(
            pin_strap_pkg::mode_t'({modc_s, pin_s.e[6], pin_s.e[5]}),
            pin_s.k[7]);
      end
   end

   assign osc_select_strap = osc_reg;
   assign op_mode          = mode_reg;
   assign rom_enable_bit   = rom_reg;

   // ****************************************************************
   // register bus
   // ****************************************************************
   logic [pin_strap_pkg::CTRL_W-1:0] ctrl_reg;
   logic [pin_strap_pkg::KWU_W-1:0]  kwu_reg;
   logic [pin_strap_pkg::WAKE_W-1:0] wake_reg;
   logic                             wr_pend_reg;
   logic [7:0]                       wr_ofs_reg;
   logic                             acc;
   logic [31:0]                      rd_next;

   assign acc       = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wr_pend_reg <= 1'b0;
         wr_ofs_reg  <= 8'h00;
      end else begin
         wr_pend_reg <= acc && hwrite;
         wr_ofs_reg  <= haddr[7:0];
      end
   end

   // unmapped offsets read zero and drop writes
   always_comb begin
      rd_next = 32'h0000_0000;
      unique case (haddr[7:0])
         pin_strap_pkg::OFS_CTRL:  rd_next[5:0]  = ctrl_reg;
         pin_strap_pkg::OFS_KWU:   rd_next[11:0] = kwu_reg;
         pin_strap_pkg::OFS_WAKE:  rd_next[13:0] = wake_reg;
         pin_strap_pkg::OFS_STRAP: rd_next[4:0]  = {rom_reg, mode_reg,
                                                   osc_reg};
         default:                  rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         hrdata <= 32'h0000_0000;
      end else if (acc && !hwrite) begin
         hrdata <= rd_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ctrl_reg <= pin_strap_pkg::CTRL_RST;
      end else if (wr_pend_reg && wr_ofs_reg == pin_strap_pkg::OFS_CTRL) begin
         ctrl_reg <= hwdata[5:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         kwu_reg <= pin_strap_pkg::KWU_RST;
      end else if (wr_pend_reg && wr_ofs_reg == pin_strap_pkg::OFS_KWU) begin
         kwu_reg <= hwdata[11:0];
      end
   end

   // ****************************************************************
   // wakeup sources
   // ****************************************************************
   logic [11:0] key_lvl;
   logic [11:0] key_prev_reg;
   logic [11:0] key_fall;
   logic [13:0] wake_set;
   logic [13:0] wake_clr;

   assign key_lvl  = {pin_s.j[7:6], pin_s.j[1:0], pin_s.h};
   assign key_fall = key_prev_reg & ~key_lvl & kwu_reg;
   assign wake_set = {key_fall, ~nmi_n_s, ~irq_n_s};
   assign wake_clr = (wr_pend_reg && wr_ofs_reg == pin_strap_pkg::OFS_WAKE)
                     ? hwdata[13:0] : 14'h0000;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         key_prev_reg <= 12'hfff;
      end else begin
         key_prev_reg <= key_lvl;
      end
   end

   // a new event beats a write-one-to-clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wake_reg <= pin_strap_pkg::WAKE_RST;
      end else begin
         wake_reg <= (wake_reg & ~wake_clr) | wake_set;
      end
   end

   assign maskable_irq_in    = ~irq_n_s;
   assign nonmaskable_irq_in = ~nmi_n_s;
   assign key_wakeup_irq     = |wake_reg[13:2];
   // level inputs wake directly so a held request is never missed
   assign wake_req = ~irq_n_s | ~nmi_n_s | key_wakeup_irq;

   // ****************************************************************
   // bus clock divider
   // ****************************************************************
   logic bclk_reg;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         bclk_reg <= 1'b0;
      end else begin
         bclk_reg <= ~bclk_reg;
      end
   end

   // ****************************************************************
   // pin multiplexer
   // ****************************************************************
   pin_strap_pkg::pins_out_t po_next;
   logic                     i2c_mode;
   logic                     tagging;

   assign i2c_mode = ctrl_reg[pin_strap_pkg::CTRL_I2C];
   assign tagging  = ctrl_reg[pin_strap_pkg::CTRL_TAG];

   always_comb begin
      po_next = gpio;
      if (expanded) begin
         po_next.a_oe = 8'hff;
         po_next.b_oe = 8'hff;
         if (bus.addr_phase) begin
            po_next.a_o = bus.addr[15:8];
            po_next.b_o = bus.addr[7:0];
         end else begin
            po_next.a_o = bus.wdata[15:8];
            po_next.b_o = bus.wdata[7:0];
            po_next.a_oe = {8{bus.write}};
            po_next.b_oe = {8{bus.write}};
         end
         po_next.k_o[5:0]  = bus.addr[19:14];
         po_next.k_oe[5:0] = 6'h3f;
         po_next.k_o[7]    = bus.chip_sel_n;
         po_next.k_oe[7]   = 1'b1;
         po_next.e_o[2]    = ~bus.write;
         po_next.e_oe[2]   = 1'b1;
         if (ctrl_reg[pin_strap_pkg::CTRL_FREE]) begin
            po_next.e_o[7]  = bus.free_cycle;
            po_next.e_oe[7] = 1'b1;
         end
         if (tagging) begin
            po_next.e_oe[3] = 1'b0;
         end else if (ctrl_reg[pin_strap_pkg::CTRL_STRB]) begin
            po_next.e_o[3]  = bus.low_strobe_n;
            po_next.e_oe[3] = 1'b1;
         end
      end
      if (ctrl_reg[pin_strap_pkg::CTRL_PIPE]) begin
         po_next.e_o[6:5]  = bus.queue_track;
         po_next.e_oe[6:5] = 2'b11;
      end
      if (ctrl_reg[pin_strap_pkg::CTRL_BCLK]) begin
         po_next.e_o[4]  = bclk_reg;
         po_next.e_oe[4] = 1'b1;
      end
      po_next.e_oe[1:0] = 2'b00;
      if (i2c_mode) begin
         po_next.j_o[7:6]  = 2'b00;
         po_next.j_oe[7:6] = {i2c_scl_low, i2c_sda_low};
      end else begin
         po_next.j_o[7]  = net_tx;
         po_next.j_oe[7] = 1'b1;
         po_next.j_oe[6] = 1'b0;
      end
   end

   // nothing is driven during reset so every strap pin reads its level
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pins_out <= '0;
      end else if (in_reset_reg) begin
         pins_out <= '0;
      end else begin
         pins_out <= po_next;
      end
   end

   // ****************************************************************
   // inputs back to the core
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         bus_rdata    <= 16'h0000;
         net_rx       <= 1'b1;
         i2c_scl_in   <= 1'b1;
         i2c_sda_in   <= 1'b1;
         tag_low_half <= 1'b0;
      end else begin
         bus_rdata    <= {pin_s.a, pin_s.b};
         net_rx       <= i2c_mode ? 1'b1 : pin_s.j[6];
         i2c_scl_in   <= i2c_mode ? pin_s.j[7] : 1'b1;
         i2c_sda_in   <= i2c_mode ? pin_s.j[6] : 1'b1;
         tag_low_half <= expanded && tagging && !pin_s.e[3];
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   a_osc_capture: assert property (@(posedge ref_clk)
      disable iff (!nrst) capture |=> osc_reg == $past(pin_s.e[7]))
      else $error("oscillator strap not captured");
   a_osc_default: assert property (@(posedge ref_clk)
      !nrst |=> osc_reg == pin_strap_pkg::OSC_LOOP)
      else $error("oscillator strap reset default wrong");
   a_mode_capture: assert property (@(posedge ref_clk)
      disable iff (!nrst) capture |=> mode_reg[1:0] == $past(pin_s.e[6:5]))
      else $error("mode straps not captured");
   a_strap_hold: assert property (@(posedge ref_clk)
      disable iff (!nrst) !capture |=> $stable({mode_reg, osc_reg, rom_reg}))
      else $error("strap changed outside reset release");
   a_rom_fixed: assert property (@(posedge ref_clk)
      disable iff (!nrst) capture && {modc_s, pin_s.e[6:5]} == 3'b000
      |=> rom_reg)
      else $error("rom enable default wrong");
   a_port_k_addr: assert property (@(posedge ref_clk)
      disable iff (!nrst) expanded ##1 !in_reset_reg
      |-> pins_out.k_o[5:0] == $past(bus.addr[19:14]))
      else $error("expanded address missing on port k");
   a_rw_drive: assert property (@(posedge ref_clk)
      disable iff (!nrst) expanded |=> pins_out.e_oe[2]
                   && pins_out.e_o[2] == !$past(bus.write))
      else $error("read/write not driven");
   a_key_wake: assert property (@(posedge ref_clk)
      disable iff (!nrst) |key_fall |=> key_wakeup_irq && wake_req)
      else $error("key wakeup lost");
   a_nmi_wake: assert property (@(posedge ref_clk)
      disable iff (!nrst) !nmi_n_s |=> wake_reg[pin_strap_pkg::WAKE_NMI])
      else $error("non-maskable request not flagged");
   a_bclk_out: assert property (@(posedge ref_clk)
      disable iff (!nrst) ctrl_reg[pin_strap_pkg::CTRL_BCLK] && !in_reset_reg
      |=> pins_out.e_oe[4] && pins_out.e_o[4] == $past(bclk_reg))
      else $error("bus clock not on port e bit 4");

endmodule

// ===== src/pin_strap_pkg.sv
// constants, types and decode helpers of the pin-function and strap block
// assumes a single 50 MHz ref_clk domain and word-wide ahb-lite access
package pin_strap_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_KWU   = 8'h04;
   localparam logic [7:0] OFS_WAKE  = 8'h08;
   localparam logic [7:0] OFS_STRAP = 8'h0c;

   localparam int CTRL_FREE  = 0;
   localparam int CTRL_BCLK  = 1;
   localparam int CTRL_STRB  = 2;
   localparam int CTRL_PIPE  = 3;
   localparam int CTRL_I2C   = 4;
   localparam int CTRL_TAG   = 5;
   localparam int CTRL_W     = 6;
   localparam logic [5:0] CTRL_RST = 6'h00;

   // key wakeup enables: port h [7:0], port j bits 7,6,1,0 in [11:8]
   localparam int KWU_W = 12;
   localparam logic [11:0] KWU_RST = 12'h000;

   // wake flags: irq, nmi, then the twelve key wakeup flags
   localparam int WAKE_IRQ  = 0;
   localparam int WAKE_NMI  = 1;
   localparam int WAKE_KEY  = 2;
   localparam int WAKE_W    = 14;
   localparam logic [13:0] WAKE_RST = 14'h0000;

   localparam int STRAP_OSC  = 0;
   localparam int STRAP_MODE = 1;
   localparam int STRAP_ROM  = 4;

   localparam logic OSC_LOOP = 1'b1;
   localparam logic OSC_FULL = 1'b0;

   // bus clock: one ref_clk cycle per half period
   localparam int BCLK_HALF = 1;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      MODE_SPECIAL_SINGLE = 3'b000,
      MODE_EMU_NARROW     = 3'b001,
      MODE_SPECIAL_TEST   = 3'b010,
      MODE_EMU_WIDE       = 3'b011,
      MODE_NORMAL_SINGLE  = 3'b100,
      MODE_NORMAL_NARROW  = 3'b101,
      MODE_PERIPH_TEST    = 3'b110,
      MODE_NORMAL_WIDE    = 3'b111
   } mode_t;

   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] e;
      logic [7:0] h;
      logic [7:0] j;
      logic [7:0] k;
   } pins_in_t;

   typedef struct packed {
      logic [7:0] a_o;
      logic [7:0] a_oe;
      logic [7:0] b_o;
      logic [7:0] b_oe;
      logic [7:0] e_o;
      logic [7:0] e_oe;
      logic [7:0] j_o;
      logic [7:0] j_oe;
      logic [7:0] k_o;
      logic [7:0] k_oe;
   } pins_out_t;

   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] wdata;
      logic        addr_phase;
      logic        write;
      logic        low_strobe_n;
      logic        free_cycle;
      logic        chip_sel_n;
      logic [1:0]  queue_track;
   } ext_bus_t;

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   function automatic logic is_expanded(input mode_t m);
      return m == MODE_EMU_NARROW || m == MODE_EMU_WIDE ||
             m == MODE_NORMAL_NARROW || m == MODE_NORMAL_WIDE;
   endfunction

   function automatic logic rom_reset(input mode_t m, input logic strap);
      logic r;
      r = 1'b0;
      unique case (m)
         MODE_NORMAL_NARROW,
         MODE_NORMAL_WIDE:    r = strap;
         MODE_SPECIAL_SINGLE,
         MODE_NORMAL_SINGLE,
         MODE_PERIPH_TEST:    r = 1'b1;
         MODE_EMU_NARROW,
         MODE_EMU_WIDE,
         MODE_SPECIAL_TEST:   r = 1'b0;
      endcase
      return r;
   endfunction

endpackage

// ===== src/sync2.sv
// two-stage synchroniser for a vector of unrelated levels
// assumes each bit is sampled on its own; no bus coherence is given
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   // ****************************************************************
   // stages
   // ****************************************************************
   // no reset: straps must keep flowing through while nrst is low
   logic [W-1:0] meta_reg;

   always_ff @(posedge ref_clk) begin
      meta_reg <= d;
   end

   always_ff @(posedge ref_clk) begin
      q <= meta_reg;
   end

endmodule
